/* File: design/asrc_serial_ports_and_control.sv */
// Serial input and output ports, sample buffer pointers, mute and rate tracking.
// Assumes bit clocks far slower than aclk; registers over AXI4-Lite.
`timescale 1ns/1ns
`include "asrc_cfg.svh"
module asrc_serial_ports_and_control #(
  parameter int AW = 8 // Buffer address width, 2**AW stereo samples
) (
  input wire logic aclk, // Master clock, 20 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [7:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic in_data, // Serial input data
  input wire logic in_bit_clock, // Input bit clock
  input wire logic in_word_clock, // Input word clock
  input wire logic in_channel_clock, // Input left/right clock
  output logic out_data, // Serial output data
  input wire logic out_bit_clock, // Output bit clock
  input wire logic out_word_clock, // Output word clock
  input wire logic out_channel_clock, // Output left/right clock
  input wire logic short_latency_sel, // High: shallow buffer
  input wire logic slow_settle_sel, // High: slow rate tracking
  input wire logic mute_in, // High forces output to zero
  output logic mute_req, // High while buffer data invalid
  output logic irq // Level interrupt
);
  localparam int W = `ASRC_WORD_W;
  localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
  localparam logic [AW:0] SHORT_FILL = (AW + 1)'(`ASRC_SHORT_FILL);
  localparam logic [AW:0] LONG_FILL = (AW + 1)'(`ASRC_LONG_FILL);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [2:0] ist;
    logic [2:0] ien;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    asrc_pkg::axi_resp_t bresp;
    logic rvalid;
    logic [31:0] rdata;
    asrc_pkg::axi_resp_t rresp;
    logic rx_active;
    logic rx_skip;
    logic rx_left;
    logic [4:0] rx_cnt;
    logic [W-1:0] rx_sh;
    logic [W-1:0] left_hold;
    logic [W-1:0] tx_sh;
    logic out_data;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [7:0] mute_cnt;
    logic short_q;
    logic [15:0] per_cnt;
    logic [19:0] rate_est;
  } top_st_t;
  top_st_t st;
  top_st_t next_st;

  if (AW < 4 || AW > 12 || (2 ** AW) <= `ASRC_LONG_FILL) begin : g_chk
    $error("buffer depth cannot hold the deep fill level");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers and buffer
  // ----------------------------------------------------------------------
  logic [9:0] pin_lvl;
  logic [9:0] pin_rise;
  logic [9:0] pin_fall;
  logic wr_en;
  logic [2*W-1:0] mem_rdata;

  link_sync #(.W(10)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({mute_in, slow_settle_sel, short_latency_sel, out_channel_clock, out_word_clock,
      out_bit_clock, in_channel_clock, in_word_clock, in_bit_clock, in_data}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  sample_mem #(.AW(AW), .DW(2 * W)) u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(wr_en),
    .waddr(st.wr_ptr[AW-1:0]),
    .wdata({st.left_hold, st.rx_sh}),
    .raddr(st.rd_ptr[AW-1:0]),
    .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  logic in_samp, in_frame, out_chg, out_frame, crossing, aw_hs, w_hs, do_wr;
  logic [AW:0] fill;
  logic [W-1:0] word, mask;
  logic [4:0] width;
  logic [7:0] wa;
  logic [31:0] wd, bm;
  logic [2:0] clr, ev;
  logic [20:0] diff;

  // Handshake outputs straight from state
  assign awready = !st.aw_got && !st.bvalid;
  assign wready = !st.w_got && !st.bvalid;
  assign arready = !st.rvalid;
  assign aw_hs = awvalid && awready;
  assign w_hs = wvalid && wready;

  always_comb begin
    next_st = st;
    wr_en = 1'b0;
    crossing = 1'b0;
    clr = 3'h0;
    ev = 3'h0;
    fill = st.wr_ptr - st.rd_ptr;
    in_samp = st.ctrl[`ASRC_IN_POL_BIT] ? pin_fall[1] : pin_rise[1];
    in_frame = st.ctrl[`ASRC_IN_FRM_BIT] ? (pin_rise[3] | pin_fall[3]) : pin_rise[2];
    out_chg = st.ctrl[`ASRC_OUT_POL_BIT] ? pin_rise[4] : pin_fall[4];
    // word clock ignored when channel framing
    out_frame = st.ctrl[`ASRC_OUT_FRM_BIT] ? (pin_rise[6] | pin_fall[6]) : pin_rise[5];
    width = st.ctrl[`ASRC_WIDTH_LSB +: 5];
    if (width < 5'(`ASRC_MIN_W)) width = 5'(`ASRC_MIN_W);
    if (width > 5'(W)) width = 5'(W);
    mask = {W{1'b1}} << (5'(W) - width);
    // high level is the left channel
    word = (pin_lvl[6] ? mem_rdata[2*W-1:W] : mem_rdata[W-1:0]) & mask;

    // Input port: a new frame closes the previous word
    if (in_frame) begin
      if (st.rx_active && st.rx_left) next_st.left_hold = st.rx_sh;
      wr_en = st.rx_active && !st.rx_left;
      next_st.rx_active = 1'b1;
      // skip one bit after the event
      next_st.rx_skip = st.ctrl[`ASRC_IN_DLY_BIT];
      next_st.rx_cnt = 5'h0;
      next_st.rx_sh = '0;
      next_st.rx_left = pin_lvl[3];
    end else if (in_samp && st.rx_active) begin
      if (st.rx_skip) begin
        next_st.rx_skip = 1'b0;
      end else if (st.rx_cnt < 5'(`ASRC_IN_MAX)) begin
        // Short words leave the low bits zero
        next_st.rx_sh[5'(W - 1) - st.rx_cnt] = pin_lvl[0];
        next_st.rx_cnt = st.rx_cnt + 5'h1;
      end
    end

    // Writer side of the buffer; a full buffer is an overflow crossing
    if (wr_en) begin
      if (fill == DEPTH) crossing = 1'b1;
      else next_st.wr_ptr = st.wr_ptr + (AW + 1)'(1);
    end

    // frame period filter, shift by settle mode
    next_st.per_cnt = (st.per_cnt == 16'hFFFF) ? st.per_cnt : st.per_cnt + 16'h1;
    diff = $signed({1'b0, st.per_cnt, 4'h0}) - $signed({1'b0, st.rate_est});
    if (wr_en) begin
      next_st.per_cnt = 16'h1; // Write cycle already counts toward the next period
      next_st.rate_est = st.rate_est + 20'(pin_lvl[8] ? ($signed(diff) >>> `ASRC_SLOW_SHIFT)
        : ($signed(diff) >>> `ASRC_FAST_SHIFT));
    end

    // Output port: load at frame event, shift at change edge
    if (out_frame) begin
      // MSB now or one bit later
      next_st.out_data = st.ctrl[`ASRC_OUT_DLY_BIT] ? 1'b0 : word[W-1];
      next_st.tx_sh = st.ctrl[`ASRC_OUT_DLY_BIT] ? word : (word << 1);
      if (!pin_lvl[6]) begin
        // Right word loaded: step the reader, count mute frames
        if (fill == '0) crossing = 1'b1;
        else next_st.rd_ptr = st.rd_ptr + (AW + 1)'(1);
        if (st.mute_cnt != 8'h0) next_st.mute_cnt = st.mute_cnt - 8'h1;
        if (st.mute_cnt == 8'h1) ev[`ASRC_EV_UNMUTE] = 1'b1;
      end
    end else if (out_chg) begin
      next_st.out_data = st.tx_sh[W-1];
      next_st.tx_sh = st.tx_sh << 1;
    end
    if (pin_lvl[9]) next_st.out_data = 1'b0;

    next_st.short_q = pin_lvl[7];
    if (st.short_q != pin_lvl[7]) begin
      crossing = 1'b1;
      ev[`ASRC_EV_LAT] = 1'b1;
    end
    if (crossing) begin
      next_st.mute_cnt = 8'(`ASRC_MUTE_FRAMES);
      next_st.rd_ptr = st.wr_ptr - (pin_lvl[7] ? SHORT_FILL : LONG_FILL);
      ev[`ASRC_EV_CROSS] = 1'b1;
    end

    // AXI write: address and data in either order
    if (aw_hs) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = awaddr;
    end
    if (w_hs) begin
      next_st.w_got = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    wa = aw_hs ? awaddr : st.awaddr;
    wd = w_hs ? wdata : st.wdata;
    bm = {{8{w_hs ? wstrb[3] : st.wstrb[3]}}, {8{w_hs ? wstrb[2] : st.wstrb[2]}},
      {8{w_hs ? wstrb[1] : st.wstrb[1]}}, {8{w_hs ? wstrb[0] : st.wstrb[0]}}};
    do_wr = (aw_hs || st.aw_got) && (w_hs || st.w_got);
    if (do_wr) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = asrc_pkg::RESP_OKAY;
      unique case (wa)
        `ASRC_CTRL_OFS: next_st.ctrl = ((st.ctrl & ~bm) | (wd & bm)) & `ASRC_CTRL_MASK;
        `ASRC_IRQ_CLR_OFS: clr = wd[2:0] & bm[2:0];
        `ASRC_IRQ_EN_OFS: next_st.ien = (st.ien & ~bm[2:0]) | (wd[2:0] & bm[2:0]);
        `ASRC_STAT_OFS, `ASRC_IRQ_STAT_OFS, `ASRC_RATE_OFS: ;
        default: next_st.bresp = asrc_pkg::RESP_SLVERR;
      endcase
    end else if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    // New events win over a clear in the same cycle
    next_st.ist = (st.ist & ~clr) | ev;

    // AXI read
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = asrc_pkg::RESP_OKAY;
      unique case (araddr)
        `ASRC_CTRL_OFS: next_st.rdata = st.ctrl;
        `ASRC_STAT_OFS: next_st.rdata = {15'(fill), 14'h0, pin_lvl[8], pin_lvl[7], mute_req};
        `ASRC_IRQ_STAT_OFS: next_st.rdata = {29'h0, st.ist};
        `ASRC_IRQ_EN_OFS: next_st.rdata = {29'h0, st.ien};
        `ASRC_RATE_OFS: next_st.rdata = {12'h0, st.rate_est};
        `ASRC_IRQ_CLR_OFS: next_st.rdata = 32'h0;
        default: begin
          next_st.rdata = 32'h0;
          next_st.rresp = asrc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.ctrl <= `ASRC_CTRL_RST;
      st.rd_ptr <= '0 - LONG_FILL;
    end else begin
      st <= next_st;
    end
  end

  // Outputs from state
  assign out_data = st.out_data;
  assign mute_req = st.mute_cnt != 8'h0;
  assign irq = |(st.ist & st.ien);
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_MUTE_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_lvl[9] |=> !out_data) else $error("output not zero while muted");
  AST_CROSS_MUTE: assert property (@(posedge aclk) disable iff (!aresetn)
    crossing |=> mute_req && st.mute_cnt == 8'h80) else $error("crossing did not mute");
  AST_MUTE_END: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.mute_cnt == 8'h1 && out_frame && !pin_lvl[6] && !crossing) |=> !mute_req)
    else $error("mute request stuck after count");
  AST_OUT_DLY: assert property (@(posedge aclk) disable iff (!aresetn)
    (out_frame && st.ctrl[`ASRC_OUT_DLY_BIT]) |=> !out_data ##0 st.tx_sh == $past(word))
    else $error("delayed MSB driven too early");
  AST_OUT_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
    (!out_frame && !out_chg && !pin_lvl[9]) |=> $stable(out_data))
    else $error("output changed off its edge");
  AST_IN_DLY: assert property (@(posedge aclk) disable iff (!aresetn)
    (in_frame && st.ctrl[`ASRC_IN_DLY_BIT]) |=> st.rx_skip && st.rx_cnt == 5'h0)
    else $error("input delay not applied");
  AST_IN_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.rx_cnt != $past(st.rx_cnt) && st.rx_cnt != 5'h0) |-> $past(in_samp))
    else $error("input bit taken off its edge");
  AST_IRQ_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    (crossing && st.ien[`ASRC_EV_CROSS]) |=> irq) else $error("crossing interrupt lost");
  AST_B_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> bvalid && $stable(bresp)) else $error("write response dropped");
endmodule

/* File: design/asrc_cfg.svh */
// Constants for the stereo sample-rate converter serial ports and control.
// Assumes a 20 MHz master clock and an AXI4-Lite register bus of 32-bit words.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef ASRC_CFG_SVH
`define ASRC_CFG_SVH

// Register byte offsets
`define ASRC_CTRL_OFS 8'h00
`define ASRC_STAT_OFS 8'h04
`define ASRC_IRQ_STAT_OFS 8'h08
`define ASRC_IRQ_CLR_OFS 8'h0C
`define ASRC_IRQ_EN_OFS 8'h10
`define ASRC_RATE_OFS 8'h14

// Control fields
`define ASRC_IN_POL_BIT 0
`define ASRC_OUT_POL_BIT 1
`define ASRC_IN_FRM_BIT 2
`define ASRC_OUT_FRM_BIT 3
`define ASRC_IN_DLY_BIT 4
`define ASRC_OUT_DLY_BIT 5
`define ASRC_WIDTH_LSB 8
`define ASRC_CTRL_MASK 32'h00001F3F
`define ASRC_CTRL_RST 32'h00001800

// Event bits
`define ASRC_EV_CROSS 0
`define ASRC_EV_UNMUTE 1
`define ASRC_EV_LAT 2

// Word and timing figures
`define ASRC_WORD_W 24
`define ASRC_IN_MAX 20
`define ASRC_MIN_W 4
`define ASRC_MUTE_FRAMES 128
`define ASRC_NOMINAL_FS_HZ 48000
`define ASRC_SHORT_DELAY_US 700
`define ASRC_LONG_DELAY_US 3000
`define ASRC_SHORT_FILL ((`ASRC_SHORT_DELAY_US * `ASRC_NOMINAL_FS_HZ) / 1000000)
`define ASRC_LONG_FILL ((`ASRC_LONG_DELAY_US * `ASRC_NOMINAL_FS_HZ) / 1000000)
`define ASRC_SLOW_SETTLE_MS 800
`define ASRC_FAST_SETTLE_MS 200
// Settle times differ by four, two bits of filter shift
`define ASRC_FAST_SHIFT 4
`define ASRC_SLOW_SHIFT 6

`endif

/* File: design/asrc_pkg.sv */
// Types shared by the converter port logic.
// Assumes the constants header is included where figures are needed.
package asrc_pkg;
  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_t;
endpackage

/* File: design/link_sync.sv */
// Two-stage synchroniser with edge detection for pins from outside aclk.
// Assumes pins toggle no faster than a few aclk periods.
`timescale 1ns/1ns
module link_sync #(
  parameter int W = 1
) (
  input wire logic aclk, // Master clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [W-1:0] din, // Raw pins
  output logic [W-1:0] lvl, // Synchronised level
  output logic [W-1:0] rise, // One-cycle rising pulse
  output logic [W-1:0] fall // One-cycle falling pulse
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_t;
  sync_t st;
  sync_t next_st;

  if (W < 1) begin : g_chk
    $error("link_sync needs at least one bit");
  end

  // Stage one feeds stage two only
  always_comb begin
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lvl = st.s2;
  assign rise = st.s2 & ~st.s3;
  assign fall = ~st.s2 & st.s3;
endmodule

/* File: design/sample_mem.sv */
// Stereo sample buffer with a registered read port.
// Assumes one write and one read address per cycle.
`timescale 1ns/1ns
module sample_mem #(
  parameter int AW = 8,
  parameter int DW = 48
) (
  input wire logic aclk, // Master clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] waddr, // Write address
  input wire logic [DW-1:0] wdata, // Write data
  input wire logic [AW-1:0] raddr, // Read address
  output logic [DW-1:0] rdata // Registered read data
);
  typedef struct packed {
    logic [DW-1:0] rdata;
  } mem_st_t;
  mem_st_t st;
  mem_st_t next_st;
  logic [DW-1:0] mem [2**AW];

  if (AW < 2 || DW < 1) begin : g_chk
    $error("sample_mem size out of range");
  end

  // Read follows the address one cycle later
  always_comb begin
    next_st.rdata = mem[raddr];
  end

  // Storage itself is not reset; only the read register is
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
endmodule

/* File: verification/audio_far_end.sv */
// Far side model: a source feeding the input port and a sink clocking the output port.
// Assumes the bench changes its controls only between checks, never expects glitch-free swaps.
`timescale 1ns/1ns
module audio_far_end #(
  parameter logic [19:0] LEFT = 20'hA5C3F, // Left word sent every frame
  parameter logic [19:0] RIGHT = 20'h3B16D, // Right word sent every frame
  parameter int BITS = 25 // Bit periods per channel
) (
  input wire logic run, // Starts the clocks
  input wire logic ipol, // Input bit clock inverted
  input wire logic opol, // Output bit clock inverted
  input wire logic idly, // Input first bit one period late
  input wire logic iwon, // Input word clock pulses
  input wire logic owon, // Output word clock pulses
  input wire logic out_data, // Device serial output
  output logic in_data, // Source data
  output logic in_bit_clock, // Source bit clock
  output logic in_word_clock, // Source word clock
  output logic in_channel_clock, // Source channel clock
  output logic out_bit_clock, // Sink bit clock
  output logic out_word_clock, // Sink word clock
  output logic out_channel_clock, // Sink channel clock
  output logic [24:0] cap_left, // Last left word taken
  output logic [24:0] cap_right, // Last right word taken
  output logic frame_tog // Toggles after each right word
);
  logic base;
  logic [24:0] sh;
  logic [19:0] w;
  int b;
  // Both bit clocks come from base, each inverted by its own pol input; base falling is the change edge
  assign in_bit_clock = base ^ ipol;
  assign out_bit_clock = base ^ opol;
  // Frame generator, 400 ns bits; 7 ns offset keeps pins off the aclk edge
  initial begin
    base = 1'h1;
    in_data = 1'h0;
    in_word_clock = 1'h0;
    out_word_clock = 1'h0;
    in_channel_clock = 1'h0;
    out_channel_clock = 1'h0;
    cap_left = '0;
    cap_right = '0;
    frame_tog = 1'h0;
    sh = '0;
    wait (run);
    #7;
    forever begin
      for (int ch = 1; ch >= 0; ch--) begin
        w = (ch == 1) ? LEFT : RIGHT;
        for (int k = 0; k < BITS; k++) begin
          base = 1'h0;
          in_channel_clock = (ch == 1);
          out_channel_clock = (ch == 1);
          // word clock rises at word start
          in_word_clock = iwon && (k == 0);
          out_word_clock = owon && (k == 0);
          b = k - int'(idly);
          in_data = (b >= 0 && b < 20) ? w[19 - b] : ~in_data;
          #200 base = 1'h1;
          // Sampled late so the device's sync delay cannot race it
          #100 sh = {sh[23:0], out_data};
          #100;
        end
        if (ch == 1) begin
          cap_left = sh;
        end else begin
          cap_right = sh;
          frame_tog = ~frame_tog;
        end
      end
    end
  end
endmodule

/* File: verification/asrc_serial_ports_and_control_tb_top.sv */
// Self-checking bench: AXI4-Lite master tasks plus the far side serial model.
// Assumes both serial ports run at one rate, so no overflow or underflow crossing after the start.
`timescale 1ns/1ns
`include "asrc_cfg.svh"
module asrc_serial_ports_and_control_tb_top;
  localparam logic [19:0] LEFT = 20'hA5C3F;
  localparam logic [19:0] RIGHT = 20'h3B16D;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, out_data, mute_req, irq, frame_tog;
  logic [1:0] bresp, rresp;
  logic run = 1'h0, ipol = 1'h0, opol = 1'h0, idly = 1'h0, iwon = 1'h1, owon = 1'h1;
  logic short_sel = 1'h1, slow_sel = 1'h0, mute_in = 1'h0;
  logic in_data, in_bit_clock, in_word_clock, in_channel_clock;
  logic out_bit_clock, out_word_clock, out_channel_clock;
  logic [24:0] cap_left, cap_right;
  int fails = 0, compares = 0, mute_frames = 0;

  always #25 aclk = ~aclk;

  asrc_serial_ports_and_control dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .in_data(in_data),
    .in_bit_clock(in_bit_clock), .in_word_clock(in_word_clock),
    .in_channel_clock(in_channel_clock), .out_data(out_data), .out_bit_clock(out_bit_clock),
    .out_word_clock(out_word_clock), .out_channel_clock(out_channel_clock),
    .short_latency_sel(short_sel), .slow_settle_sel(slow_sel), .mute_in(mute_in),
    .mute_req(mute_req), .irq(irq));

  audio_far_end #(.LEFT(LEFT), .RIGHT(RIGHT), .BITS(25)) far (
    .run(run), .ipol(ipol), .opol(opol), .idly(idly), .iwon(iwon), .owon(owon),
    .out_data(out_data), .in_data(in_data), .in_bit_clock(in_bit_clock),
    .in_word_clock(in_word_clock), .in_channel_clock(in_channel_clock),
    .out_bit_clock(out_bit_clock), .out_word_clock(out_word_clock),
    .out_channel_clock(out_channel_clock), .cap_left(cap_left), .cap_right(cap_right),
    .frame_tog(frame_tog));

  // Right-channel output frames seen while muted
  always @(negedge out_channel_clock) if (mute_req === 1'h1) mute_frames++;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Master holds each channel until its own handshake edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        done = 1'h1;
        bready <= 1'h0;
        check(bresp, er);
      end
    end
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic done;
    done = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        done = 1'h1;
        rready <= 1'h0;
        check(rdata & m, e);
        check(rresp, (a > 8'h14) ? asrc_pkg::RESP_SLVERR : asrc_pkg::RESP_OKAY);
      end
    end
    @(posedge aclk);
  endtask

  task automatic wait_frames(input int n);
    repeat (n) @(frame_tog);
    @(posedge aclk);
  endtask

  // Output word as the sink sees it: width bits kept, delay shifts one bit
  function automatic logic [31:0] exp_word(input logic [19:0] w, input int width,
                                           input logic dly);
    logic [23:0] v;
    v = {w, 4'h0} & ~(24'hFFFFFF >> width);
    return dly ? {7'h00, 1'h0, v} : {7'h00, v, 1'h0};
  endfunction

  task automatic cmp_caps(input int width, input logic dly);
    check({7'h00, cap_left}, exp_word(LEFT, width, dly));
    check({7'h00, cap_right}, exp_word(RIGHT, width, dly));
  endtask

  task automatic t_regs;
    axi_read(`ASRC_CTRL_OFS, 32'h00001800, 32'hFFFFFFFF);
    axi_read(`ASRC_IRQ_EN_OFS, 32'h0, 32'hFFFFFFFF);
    axi_read(8'h40, 32'h0, 32'hFFFFFFFF);
    axi_write(8'h40, 32'h1, asrc_pkg::RESP_SLVERR);
  endtask

  // Latency select high at reset counts as a crossing
  task automatic t_mute;
    int n;
    check(mute_req, 1'h1);
    axi_write(`ASRC_IRQ_EN_OFS, 32'h3, asrc_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(irq, 1'h1);
    axi_read(`ASRC_IRQ_STAT_OFS, 32'h5, 32'h7);
    axi_write(`ASRC_IRQ_CLR_OFS, 32'h5, asrc_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(irq, 1'h0);
    n = 0;
    while (mute_req !== 1'h0 && n < 60000) begin
      @(posedge aclk);
      n++;
    end
    check(mute_frames, 32'h80);
    repeat (2) @(posedge aclk);
    check(irq, 1'h1);
    axi_write(`ASRC_IRQ_EN_OFS, 32'h0, asrc_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(irq, 1'h0);
    axi_read(`ASRC_IRQ_STAT_OFS, 32'h2, 32'h7);
    axi_write(`ASRC_IRQ_CLR_OFS, 32'h2, asrc_pkg::RESP_OKAY);
    axi_read(`ASRC_IRQ_STAT_OFS, 32'h0, 32'h7);
    // Frame is 50 bits of 400 ns, 400 cycles, kept x16; filter may sit a step low
    axi_read(`ASRC_RATE_OFS, 32'h00001800, 32'hFFFFFE00);
    wait_frames(2);
    cmp_caps(24, 1'h0);
  endtask

  // Output delay, inverted clock, channel framing without word clock, width 8
  task automatic t_out;
    logic [31:0] cv [4];
    cv = '{32'h00001820, 32'h00001802, 32'h00001808, 32'h00000800};
    for (int i = 0; i < 4; i++) begin
      axi_write(`ASRC_CTRL_OFS, cv[i], asrc_pkg::RESP_OKAY);
      opol <= cv[i][1];
      owon <= !cv[i][3];
      axi_read(`ASRC_CTRL_OFS, cv[i], 32'hFFFFFFFF);
      wait_frames(3);
      cmp_caps(int'(cv[i][12:8]), cv[i][5]);
    end
  endtask

  // Input side reformatted; buffer must flush before the words return
  task automatic t_in;
    axi_write(`ASRC_CTRL_OFS, 32'h00001815, asrc_pkg::RESP_OKAY);
    ipol <= 1'h1;
    idly <= 1'h1;
    iwon <= 1'h0;
    opol <= 1'h0;
    owon <= 1'h1;
    wait_frames(40);
    cmp_caps(24, 1'h0);
  endtask

  task automatic t_mute_in;
    mute_in <= 1'h1;
    wait_frames(2);
    check({7'h00, cap_left}, 32'h0);
    check({7'h00, cap_right}, 32'h0);
    mute_in <= 1'h0;
    slow_sel <= 1'h1;
    repeat (8) @(posedge aclk);
    axi_read(`ASRC_STAT_OFS, 32'h6, 32'h7);
    // Dropping the latency select re-centres deep and mutes
    short_sel <= 1'h0;
    repeat (8) @(posedge aclk);
    axi_read(`ASRC_STAT_OFS, 32'h5, 32'h7);
    axi_read(`ASRC_IRQ_STAT_OFS, 32'h5, 32'h7);
  endtask

  initial begin
    repeat (95000) @(posedge aclk);
    fails++;
    report_and_stop;
  end

  // Main sequence; reset spans three edges, sync chains clear with it
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    run <= 1'h1;
    repeat (8) @(posedge aclk);
    t_regs;
    t_mute;
    t_out;
    t_in;
    t_mute_in;
    report_and_stop;
  end
endmodule
